// ===== bench/line_diag_sva.sv
// port checks for the line fault diagnostic block
`timescale 1ns/1ps
module line_diag_sva
	import line_diag_pkg::*;
#(
	parameter int slot_cycles = slot_cycles_default
) (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire sense_t      sense_in,
	input wire logic        low_supply_signal,
	input wire logic        measurement_current_phase_seen
);
	default clocking dc @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	logic       acc;
	logic       cmd;
	logic       rdf;
	logic       cseen;
	logic [9:0] since;
	logic [7:0] last;
	// completed accesses
	assign acc = psel && penable && pready;
	assign cmd = acc && pwrite && paddr == off_read_cmd;
	assign rdf = acc && !pwrite && paddr == off_fault_flags;
	// cycles since the last read command, saturating
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			since <= 10'h3ff;
		else if (cmd)
			since <= 10'h000;
		else if (since != 10'h3ff)
			since <= since + 10'h001;
	end
	// last flags read; untrusted until a clear has surely ended
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			last  <= 8'hff;
			cseen <= 1'b0;
		end else if (cmd) begin
			cseen <= 1'b1;
		end else if (rdf) begin
			last  <= prdata[7:0];
			cseen <= cseen && since < 10'h105;
		end
	end
	ready_now_a: assert property (psel && penable |-> pready)
		else $error("pready low in access");
	unmapped_err_a: assert property (acc && paddr > off_period |-> pslverr)
		else $error("no error for unmapped address");
	phase_seen_a: assert property ($rose(sense_in.meas_phase)
		|-> ##[1:4] $rose(measurement_current_phase_seen))
		else $error("phase not seen");
	supply_flag_a: assert property (
		(sense_in.supply_low && sense_in.first_sample) [*3]
		|-> ##[1:6] low_supply_signal) else $error("low supply missed");
	supply_drop_a: assert property ($fell(low_supply_signal)
		|-> since >= 10'h0c8 && since <= 10'h12c)
		else $error("low supply dropped off time");
	supply_stat_a: assert property (acc && !pwrite &&
		paddr == off_status |-> prdata[0] == $past(low_supply_signal))
		else $error("status low supply wrong");
	clear_stat_a: assert property (acc && !pwrite &&
		paddr == off_status && since > 10'h001 && since < 10'h0c8
		|-> prdata[3]) else $error("clearing not shown");
	latch_hold_a: assert property (rdf && !cseen
		|-> (prdata[7:0] & ~last) == 8'h00)
		else $error("fault bit lost without read command");
endmodule

bind sensor_line_fault_diagnostic line_diag_sva #(
	.slot_cycles(slot_cycles)
) u_sva (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .sense_in(sense_in),
	.low_supply_signal(low_supply_signal),
	.measurement_current_phase_seen(measurement_current_phase_seen)
);

// ===== bench/sensor_lines.sv
// sensor line and heater switch model feeding the comparator inputs
`timescale 1ns/1ps
module sensor_lines
	import line_diag_pkg::*;
(
	input  wire logic   pclk,
	input  wire logic   presetn,
	input  wire sense_t fault_in,
	output sense_t      sense_out
);
	logic [6:0] tick;
	// free running count: the phase flips every 64 cycles, one period
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			tick <= 7'h00;
		else
			tick <= tick + 7'h01;
	end
	// healthy drain follows the gate; an injected fault inverts it
	always_comb begin
		sense_out = fault_in;
		sense_out.heat_drain = fault_in.heat_gate ^ fault_in.heat_drain;
		sense_out.meas_phase = tick[6];
		sense_out.first_sample = tick[5:3] == 3'h0;
	end
endmodule

// ===== bench/testbench.sv
// bench: apb access and injected line faults
`timescale 1ns/1ps
module testbench
	import line_diag_pkg::*;
;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        low_sup;
	logic        phase;
	logic [31:0] rd;
	logic        er;
	sense_t      flt;
	sense_t      sense;
	int          n_fail;
	int          compares;
	sensor_lines u_lines (.pclk(pclk), .presetn(presetn), .fault_in(flt),
		.sense_out(sense));
	// two cycles a slot keeps every window short
	sensor_line_fault_diagnostic #(.slot_cycles(2)) u_dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .sense_in(sense),
		.low_supply_signal(low_sup),
		.measurement_current_phase_seen(phase));
	always #2 pclk = ~pclk;
	task automatic wt(input int n);
		repeat (n) @(posedge pclk);
	endtask
	// one apb transfer, held until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a,
			input logic [31:0] d);
		@(posedge pclk);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic chk(input string n, input logic [31:0] e,
			input logic [31:0] g);
		compares++;
		if (g !== e) begin
			n_fail++;
			$display("wrong value %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic rdc(input string n, input logic [7:0] a,
			input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(n, e, rd);
	endtask
	// read command, then a gap long enough for the next one
	task automatic clr;
		apb(1'b1, off_read_cmd, 32'h0);
		apb(1'b0, off_status, 32'h0);
		chk("clearing", 32'h1, {31'h0, rd[3]});
		wt(300);
	endtask
	// hold a line fault n cycles, wait w more, then read the flags
	task automatic pulse(input sense_t f, input int n, input int w,
			input logic [7:0] e, input string nm);
		flt <= f;
		wt(n);
		flt <= '0;
		wt(w);
		rdc(nm, off_fault_flags, {24'h0, e});
	endtask
	task automatic results;
		if (n_fail == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial begin
		wt(20000);
		n_fail++;
		results;
	end
	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		flt = '0;
		n_fail = 0;
		compares = 0;
		wt(4);
		presetn <= 1'b1;
		rdc("flags", off_fault_flags, 32'hff);
		rdc("control", off_control, 32'h0);
		apb(1'b0, 8'h40, 32'h0);
		chk("slverr", 32'h1, {31'h0, er});
		pulse(12'h800, 20, 0, 8'hff, "vg glitch");
		pulse(12'h800, 60, 40, 8'hfc, "vg ground");
		clr;
		pulse(12'h400, 60, 0, 8'hfe, "vg battery");
		clr;
		pulse(12'h0c0, 200, 0, 8'hff, "pump glitch");
		pulse(12'h0c0, 300, 0, 8'hcf, "pump ground");
		clr;
		pulse(12'h020, 2, 0, 8'hff, "bat glitch");
		pulse(12'h020, 20, 0, 8'hef, "pump battery");
		clr;
		apb(1'b1, off_control, 32'h1);
		rdc("pump off", off_control, 32'h1);
		pulse(12'h0e0, 300, 0, 8'hff, "pump idle");
		apb(1'b1, off_control, 32'h0);
		pulse(12'h018, 4, 90, 8'h7f, "heat battery");
		pulse(12'h010, 90, 0, 8'h3f, "heat ground");
		clr;
		@(negedge sense.meas_phase);
		pulse(12'h200, 50, 0, 8'hff, "nern gnd off");
		@(posedge sense.meas_phase);
		pulse(12'h100, 50, 0, 8'hff, "nern bat off");
		pulse(12'h200, 200, 0, 8'hf3, "nern ground");
		clr;
		pulse(12'h100, 200, 0, 8'hfb, "nern battery");
		clr;
		pulse(12'h004, 70, 0, 8'hd5, "low supply");
		chk("low flag", 32'h1, {31'h0, low_sup});
		clr;
		chk("low drop", 32'h0, {31'h0, low_sup});
		rdc("final", off_fault_flags, 32'hff);
		results;
	end
endmodule

// ===== logic/line_diag_pkg.sv
// package: register map, timing and carriers for the line fault diagnostic
package line_diag_pkg;
	// register byte offsets on the apb bus
	localparam logic [7:0] off_fault_flags = 8'h00;
	localparam logic [7:0] off_control     = 8'h04;
	localparam logic [7:0] off_status      = 8'h08;
	localparam logic [7:0] off_read_cmd    = 8'h0c;
	localparam logic [7:0] off_period      = 8'h10;

	// reset values
	localparam logic [7:0] fault_flags_reset = 8'hff;
	localparam logic [0:0] control_reset     = 1'h0;

	// fault bit positions
	localparam int vg_bit_lo   = 0;
	localparam int vg_bit_hi   = 1;
	localparam int nern_bit_lo = 2;
	localparam int nern_bit_hi = 3;
	localparam int pump_bit_lo = 4;
	localparam int pump_bit_hi = 5;
	localparam int heat_bit_lo = 6;
	localparam int heat_bit_hi = 7;

	// control register field
	localparam int ctrl_pump_off_bit = 0;

	// window figures in 32nds of a measurement period
	localparam int slots_per_period = 32;
	localparam int vg_filter_slots   = 16;
	localparam int nern_wait_slots   = 4;
	localparam int nern_active_slots = 8;
	localparam int pump_gnd_slots    = 128;
	localparam int pump_bat_slots    = 2;
	localparam int heat_filter_slots = 32;

	// clear time after the read command, in ns, and clock period in ns
	localparam int clear_time_ns = 1000;
	localparam int clk_period_ns = 4;
	localparam int clear_cycles  = clear_time_ns / clk_period_ns;

	// default slot length in pclk cycles, a 32nd of the measurement period
	localparam int slot_cycles_default = 40;

	// sampled sensor comparator inputs travel together
	typedef struct packed {
		logic vg_low;
		logic vg_high;
		logic nern_low;
		logic nern_high;
		logic pump_low;
		logic pump_thresh;
		logic pump_high;
		logic heat_drain;
		logic heat_gate;
		logic supply_low;
		logic first_sample;
		logic meas_phase;
	} sense_t;
endpackage

// ===== logic/sensor_line_fault_diagnostic.sv
// line fault detection with filtering windows and an apb register file
//
// The APB register port and the register addresses were decided locally.
`timescale 1ns/1ps

module sensor_line_fault_diagnostic
	import line_diag_pkg::*;
#(
	parameter int slot_cycles = slot_cycles_default
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire sense_t      sense_in,
	output logic             low_supply_signal,
	output logic             measurement_current_phase_seen
);
	// elaboration checks: every counter below is sized for these ranges
	// the divider is 16 bits wide, so a slot is at most 65535 cycles
	if (slot_cycles < 1 || slot_cycles > 65535) begin : bad_slot
		$error("slot_cycles out of range");
	end
	// slot index and nernst counter are five bits: 32 slots a period
	if (slots_per_period != 32) begin : bad_period
		$error("slots_per_period must be 32");
	end
	// nernst counter parks at 31, so the window must end before it
	if (nern_wait_slots + nern_active_slots > 31
		|| nern_active_slots < 1) begin : bad_nernst
		$error("nernst window does not fit the slot counter");
	end
	// filter counters are eight bits and count up to the window, one past its last slot
	if (vg_filter_slots < 1 || vg_filter_slots > 255) begin : bad_vg
		$error("vg filter window out of range");
	end
	if (pump_gnd_slots < 1 || pump_gnd_slots > 255) begin : bad_pg
		$error("pump ground window out of range");
	end
	if (pump_bat_slots < 1 || pump_bat_slots > 255) begin : bad_pb
		$error("pump battery window out of range");
	end
	// heater counter stops at the last slot, one below the window
	if (heat_filter_slots < 1 || heat_filter_slots > 256) begin : bad_hf
		$error("heater window out of range");
	end
	// the restore timer is nine bits wide
	if (clear_cycles < 1 || clear_cycles > 512) begin : bad_clear
		$error("clear time does not fit the restore timer");
	end

	localparam int sw = 16;
	localparam logic [sw-1:0] slot_last = sw'(slot_cycles - 1);
	localparam logic [7:0] vg_last   = 8'(vg_filter_slots - 1);
	localparam logic [7:0] pg_last   = 8'(pump_gnd_slots - 1);
	localparam logic [7:0] pb_last   = 8'(pump_bat_slots - 1);
	localparam logic [7:0] hf_last   = 8'(heat_filter_slots - 1);
	localparam logic [4:0] nw_slots  = 5'(nern_wait_slots);
	localparam logic [4:0] na_end    = 5'(nern_wait_slots + nern_active_slots);
	localparam logic [8:0] clr_last  = 9'(clear_cycles - 1);

	// two-stage synchroniser for every pin input
	// only the second stage is read; stage one may go metastable
	sense_t sync1_reg;
	sense_t s;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_reg <= '0;
			s         <= '0;
		end else begin
			sync1_reg <= sense_in;
			s         <= sync1_reg;
		end
	end

	// slot divider: one pulse per 1/32 of a measurement period
	// every window counts these same ticks, so all stay in step
	logic [sw-1:0] div_reg;
	logic          slot_tick;
	logic [4:0]    slot_reg;
	assign slot_tick = (div_reg == slot_last);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_reg  <= '0;
			slot_reg <= '0;
		end else if (slot_tick) begin
			div_reg  <= '0;
			slot_reg <= slot_reg + 5'h01;
		end else begin
			div_reg <= div_reg + 16'h0001;
		end
	end

	// software registers
	logic       pump_off_control;
	logic [7:0] flags_reg;
	logic       read_cmd;
	logic [8:0] clr_cnt_reg;
	logic       clearing_reg;
	logic       wr_en;
	logic       rd_en;
	assign wr_en = psel && penable && pwrite;
	// read data is fetched in setup so it stands through the access
	assign rd_en = psel && !penable && !pwrite;
	assign read_cmd = wr_en && (paddr == off_read_cmd);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			pump_off_control <= control_reset[0];
		else if (wr_en && paddr == off_control)
			pump_off_control <= pwdata[ctrl_pump_off_bit];
	end

	// phase edge detection and nernst window slot counter
	// each phase edge restarts the wait before the window
	logic       phase_d_reg;
	logic [4:0] nslot_reg;
	logic       nern_open;
	logic       nern_close;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phase_d_reg <= 1'b0;
			nslot_reg   <= 5'h1f;
		end else begin
			phase_d_reg <= s.meas_phase;
			if (s.meas_phase != phase_d_reg)
				nslot_reg <= '0;
			else if (slot_tick && nslot_reg != 5'h1f)
				nslot_reg <= nslot_reg + 5'h01;
		end
	end
	assign nern_open  = (nslot_reg >= nw_slots) && (nslot_reg < na_end);
	assign nern_close = slot_tick && (nslot_reg == na_end - 5'h01);
	assign measurement_current_phase_seen = phase_d_reg;

	// nernst faults captured in the window, reported once per period
	logic nern_gnd_reg;
	logic nern_bat_reg;
	logic nern_gnd_hit;
	logic nern_bat_hit;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			nern_gnd_reg <= 1'b0;
			nern_bat_reg <= 1'b0;
		end else if (nern_close) begin
			nern_gnd_reg <= 1'b0;
			nern_bat_reg <= 1'b0;
		end else if (nern_open) begin
			if (s.meas_phase && s.nern_low)
				nern_gnd_reg <= 1'b1;
			if (!s.meas_phase && s.nern_high)
				nern_bat_reg <= 1'b1;
		end
	end
	// one result per window, and one window per period
	// the closing cycle itself still counts towards the result
	assign nern_gnd_hit = nern_close
		&& (nern_gnd_reg || (s.meas_phase && s.nern_low));
	assign nern_bat_hit = nern_close
		&& (nern_bat_reg || (!s.meas_phase && s.nern_high));

	// slot-counting filters: condition must hold for the whole window
	logic [7:0] vgl_reg;
	logic [7:0] vgh_reg;
	logic [7:0] pgl_reg;
	logic [7:0] pbh_reg;
	logic       vgl_hit;
	logic       vgh_hit;
	logic       pgl_hit;
	logic       pbh_hit;
	logic       pump_gnd_cond;
	logic       pump_bat_cond;
	// pump off mutes both pump checks and restarts their counts
	assign pump_gnd_cond = !pump_off_control && s.pump_low
		&& s.pump_thresh;
	assign pump_bat_cond = !pump_off_control && s.pump_high;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			vgl_reg <= '0;
			vgh_reg <= '0;
			pgl_reg <= '0;
			pbh_reg <= '0;
		end else begin
			// a dropout restarts the count so short glitches vanish
			// trade-off: a one-cycle dropout also discards a long run
			if (!s.vg_low)
				vgl_reg <= '0;
			else if (slot_tick && vgl_reg <= vg_last)
				vgl_reg <= vgl_reg + 8'h01;
			if (!s.vg_high)
				vgh_reg <= '0;
			else if (slot_tick && vgh_reg <= vg_last)
				vgh_reg <= vgh_reg + 8'h01;
			if (!pump_gnd_cond)
				pgl_reg <= '0;
			else if (slot_tick && pgl_reg <= pg_last)
				pgl_reg <= pgl_reg + 8'h01;
			if (!pump_bat_cond)
				pbh_reg <= '0;
			else if (slot_tick && pbh_reg <= pb_last)
				pbh_reg <= pbh_reg + 8'h01;
		end
	end
	assign vgl_hit = vgl_reg > vg_last;
	assign vgh_hit = vgh_reg > vg_last;
	assign pgl_hit = pgl_reg > pg_last;
	assign pbh_hit = pbh_reg > pb_last;

	// heater filter: any event starts a window, fault stored at its end
	logic       heat_fault;
	logic       heat_run_reg;
	logic [7:0] heat_cnt_reg;
	logic       heat_seen_reg;
	logic       heat_gnd_reg;
	logic       heat_bat_reg;
	logic       heat_end;
	// a fault is a drain level that disagrees with the gate command
	// gate low: ground short or open load; gate high: battery short
	assign heat_fault = s.heat_gate ? !s.heat_drain : s.heat_drain;
	assign heat_end = heat_run_reg && slot_tick && heat_cnt_reg == hf_last;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			heat_run_reg  <= 1'b0;
			heat_cnt_reg  <= '0;
			heat_seen_reg <= 1'b0;
			heat_gnd_reg  <= 1'b0;
			heat_bat_reg  <= 1'b0;
		end else if (heat_end) begin
			heat_run_reg  <= 1'b0;
			heat_seen_reg <= 1'b0;
			heat_gnd_reg  <= 1'b0;
			heat_bat_reg  <= 1'b0;
		end else if (heat_run_reg) begin
			if (slot_tick)
				heat_cnt_reg <= heat_cnt_reg + 8'h01;
			if (heat_fault) begin
				heat_seen_reg <= 1'b1;
				heat_gnd_reg  <= heat_gnd_reg | !s.heat_gate;
				heat_bat_reg  <= heat_bat_reg | s.heat_gate;
			end
		end else if (heat_fault) begin
			heat_run_reg  <= 1'b1;
			heat_cnt_reg  <= '0;
			heat_seen_reg <= 1'b1;
			heat_gnd_reg  <= !s.heat_gate;
			heat_bat_reg  <= s.heat_gate;
		end
	end

	// low supply flag raised during the first sampling phase
	// the flag outlives the fault until a diagnostic read restores all
	logic lv_hit;
	assign lv_hit = s.supply_low && s.first_sample;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			low_supply_signal <= 1'b0;
		else if (lv_hit)
			low_supply_signal <= 1'b1;
		else if (clearing_reg && clr_cnt_reg == clr_last)
			low_supply_signal <= 1'b0;
	end

	// clear timer after the read command ends
	// restore lands at the end of the allowed time, not earlier
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clearing_reg <= 1'b0;
			clr_cnt_reg  <= '0;
		end else if (read_cmd) begin
			clearing_reg <= 1'b1;
			clr_cnt_reg  <= '0;
		end else if (clearing_reg) begin
			if (clr_cnt_reg == clr_last)
				clearing_reg <= 1'b0;
			else
				clr_cnt_reg <= clr_cnt_reg + 9'h001;
		end
	end

	// clear mask from this cycle's qualified events, active-low flags
	// events in one cycle simply merge their masks
	logic [7:0] hit_mask;
	always_comb begin
		hit_mask = '0;
		if (lv_hit) begin
			hit_mask[vg_bit_hi]   = 1'b1;
			hit_mask[nern_bit_hi] = 1'b1;
			hit_mask[pump_bit_hi] = 1'b1;
		end
		if (vgl_hit) begin
			hit_mask[vg_bit_lo] = 1'b1;
			hit_mask[vg_bit_hi] = 1'b1;
		end
		if (vgh_hit)
			hit_mask[vg_bit_lo] = 1'b1;
		if (nern_gnd_hit) begin
			hit_mask[nern_bit_lo] = 1'b1;
			hit_mask[nern_bit_hi] = 1'b1;
		end
		if (nern_bat_hit)
			hit_mask[nern_bit_lo] = 1'b1;
		if (pgl_hit) begin
			hit_mask[pump_bit_lo] = 1'b1;
			hit_mask[pump_bit_hi] = 1'b1;
		end
		if (pbh_hit)
			hit_mask[pump_bit_lo] = 1'b1;
		if (heat_end && heat_seen_reg) begin
			hit_mask[heat_bit_lo] = heat_gnd_reg;
			hit_mask[heat_bit_hi] = heat_bat_reg;
		end
	end

	// flag register: a fault in the restore cycle still lands, set wins
	// faults qualified while the restore timer runs are overwritten
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			flags_reg <= fault_flags_reset;
		else if (clearing_reg && clr_cnt_reg == clr_last)
			flags_reg <= fault_flags_reset & ~hit_mask;
		else
			flags_reg <= flags_reg & ~hit_mask;
	end
	// heater switch is not touched here; faults only flag

	// apb read mux, zero wait states
	// pready stays high: every access completes in one access cycle
	logic addr_ok;
	assign addr_ok = (paddr == off_fault_flags) || (paddr == off_control)
		|| (paddr == off_status) || (paddr == off_read_cmd)
		|| (paddr == off_period);
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !addr_ok;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			prdata <= '0;
		else if (rd_en) begin
			case (paddr)
			off_fault_flags: prdata <= {24'h000000, flags_reg};
			off_control:     prdata <= {31'h00000000, pump_off_control};
			off_status:      prdata <= {27'h0000000, nslot_reg != 5'h1f,
				clearing_reg, heat_run_reg, phase_d_reg,
				low_supply_signal};
			off_period:      prdata <= {27'h0000000, slot_reg};
			default:         prdata <= '0;
			endcase
		end
	end
endmodule
